// >>> include/lf_wakeup_pkg.sv
// Shared constants for the Manchester wake-up decoder
package lf_wakeup_pkg;

  // ==================================================
  // Register offsets (8-bit data bus)
  localparam logic [3:0] CTRL_OFF      = 4'h0;
  localparam logic [3:0] RSEL_OFF      = 4'h1;
  localparam logic [3:0] STATUS_OFF    = 4'h2;
  localparam logic [3:0] RX_DATA_OFF   = 4'h3;
  localparam logic [3:0] CODE_A_LO_OFF = 4'h4;
  localparam logic [3:0] CODE_A_HI_OFF = 4'h5;
  localparam logic [3:0] CODE_B_LO_OFF = 4'h6;
  localparam logic [3:0] CODE_B_HI_OFF = 4'h7;

  // ==================================================
  // Control register fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_IE_BIT    = 1;
  localparam int CTRL_SHORT_BIT = 2;
  localparam int CTRL_RLEN_BIT  = 3;
  localparam int CTRL_ONSEL_BIT = 4;
  localparam int CTRL_ACK_BIT   = 7;

  // ==================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [3:0] RSEL_RST = 4'h0;

  // ==================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned MED_OSC_PERIOD_NS = 8000;
  localparam int unsigned ON_SHORT_PERIODS  = 25;
  localparam int unsigned ON_LONG_PERIODS   = 265;
  localparam int unsigned HALF_BIT_NS       = 125000;
  localparam int unsigned SLOW_PERIOD_US    = 1000;
  localparam int unsigned ACQ_TIMEOUT_US    = 2000;
  localparam int unsigned ON_SHORT_CYC_DEF  = ON_SHORT_PERIODS * MED_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned ON_LONG_CYC_DEF   = ON_LONG_PERIODS * MED_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned HALF_BIT_CYC_DEF  = HALF_BIT_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  ACQ_TIMEOUT_EDGES = 7'(ACQ_TIMEOUT_US / SLOW_PERIOD_US);
  localparam logic [6:0]  PRE_TIMEOUT_EDGES = 7'h41;

  // ==================================================
  // Frame format
  localparam logic [4:0]  ACQ_ZEROS     = 5'h05;
  localparam logic [4:0]  PRE_MIN_ZEROS = 5'h08;
  localparam logic [4:0]  SYNC_HALVES   = 5'h12;
  localparam logic [17:0] SYNC_PATTERN  = 18'h3a65a;

endpackage

// >>> include/lf_sym_if.sv
// Half-bit symbol channel between run-length slicer and frame decoder
`timescale 1ns/1ps
interface lf_sym_if;
  logic en;
  logic valid;
  logic level;
  logic long_run;
  logic err;
  modport src (input en, output valid, output level, output long_run, output err);
  modport snk (output en, input valid, input level, input long_run, input err);
endinterface

// >>> verilog/lf_half_slicer.sv
// Half-bit slicer: carrier run lengths into a Manchester half-bit stream
`timescale 1ns/1ps
module lf_half_slicer
  import lf_wakeup_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_BIT_CYC_DEF
) (
  // Clock, reset, enable
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // Synchronised carrier level
  input  wire logic level_in,
  // Symbol stream
  lf_sym_if.src     sym
);

  // ==================================================
  // Run classification
  localparam logic [19:0] T_MIN = 20'(HALF_CYC / 2);
  localparam logic [19:0] T_ONE = 20'(HALF_CYC * 3 / 2);
  localparam logic [19:0] T_TWO = 20'(HALF_CYC * 5 / 2);
  localparam logic [19:0] T_MAX = 20'(HALF_CYC * 7 / 2);

  logic [19:0] run_q;
  logic        lvl_q;
  logic [1:0]  pend_q;
  logic        plvl_q;
  logic        plong_q;

  // Zero means a run too short for any valid rate
  function automatic logic [1:0] halves_of(input logic [19:0] n);
    halves_of = (n < T_MIN) ? 2'h0 : (n < T_ONE) ? 2'h1 : (n < T_TWO) ? 2'h2 : 2'h3;
  endfunction

  // Run ends on an edge; a run with no edge is a lost signal or bad rate
  wire       edge_seen = sym.en && (level_in != lvl_q);
  wire [1:0] n_halves  = halves_of(run_q);
  wire       too_long  = sym.en && (run_q >= T_MAX);
  assign sym.err      = too_long || (edge_seen && n_halves == 2'h0);
  assign sym.valid    = pend_q != 2'h0;
  assign sym.level    = plvl_q;
  assign sym.long_run = plong_q && pend_q == 2'h3;

  // ==================================================
  // Run counter; halves are replayed one per cycle after each edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_q   <= 20'h00000;
      lvl_q   <= 1'b1;
      pend_q  <= 2'h0;
      plvl_q  <= 1'b0;
      plong_q <= 1'b0;
    end else if (ce_in) begin
      if (!sym.en) begin
        run_q  <= 20'h00000;
        lvl_q  <= 1'b1;  // Frames open with carrier
        pend_q <= 2'h0;
      end else begin
        run_q <= (edge_seen || too_long) ? 20'h00001 : run_q + 20'h00001;
        if (edge_seen) begin
          lvl_q   <= level_in;
          pend_q  <= n_halves;
          plvl_q  <= lvl_q;
          plong_q <= n_halves == 2'h3;
        end else if (pend_q != 2'h0) begin
          pend_q <= pend_q - 2'h1;
        end
      end
    end
  end

  pair_emit_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && edge_seen && n_halves == 2'h2 |=> sym.valid ##1 (sym.valid || !ce_in) ##1 (!sym.valid || !ce_in))
    else $error("two-half run not replayed as two halves");

endmodule

// >>> verilog/lf_wakeup_decoder.sv
// Manchester wake-up decoder: registers, sample timing and frame state machine
// What this block does
// - Slow edge opens window, detector and oscillator on
// - No signal in window: power off again
// - Five zeros complete signal acquisition
// - Reception errors start the reset interval
// - Reception errors before the data phase never raise the interrupt
// - Signal lost before acquisition: off promptly
// - Long pulse ends preamble; too few zeros resets
// - Sixty-five slow edges of zeros time out
// - Nine-bit sync field checked against pattern
// - Code is 8 or 16 bits, MSB first
// - Short code uses low byte only
// - Code matches set flags; acknowledge clears them
// - No code match resets; match keeps receiving
// - Each eighth data bit loads byte, flags ready
// - Acknowledge clears ready flag and interrupt
// - New byte overwrites data, interrupts again
// - Code violation ends frame, flags end-of-data
// - Acknowledge or disable clears end-of-data
// - Reset-active status follows the reset interval
// - Reset interval is multiple of sample period
// - Code writes only while module disabled
// - One is no carrier in first half
// - Nominal half bit is 125 microseconds
`timescale 1ns/1ps
module lf_wakeup_decoder
  import lf_wakeup_pkg::*;
#(
  parameter int unsigned ON_SHORT_CYC = ON_SHORT_CYC_DEF,
  parameter int unsigned ON_LONG_CYC  = ON_LONG_CYC_DEF,
  parameter int unsigned HALF_BIT_CYC = HALF_BIT_CYC_DEF
) (
  // Clock, reset, clock enable
  input  wire logic       CLK_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic       CE_IN,
  // Register port
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  // Detector and slow timebase
  input  wire logic       SLOW_CLK_IN,
  input  wire logic       DET_DATA_IN,
  input  wire logic       FREQ_ERR_IN,
  // Power and interrupt
  output logic            DET_EN_OUT,
  output logic            OSC_EN_OUT,
  output logic            IRQ_OUT
);

  typedef enum logic [2:0] {OFF_S, WIN_S, ACQ_S, PRE_S, SYNC_S, CODE_S, DATA_S, RST_S} state_t;

  state_t      state_q;
  state_t      state_d;
  logic        go_rst;
  logic        enable_q;
  logic        irq_en_q;
  logic        short_q;
  logic        rlen_q;
  logic        onsel_q;
  logic [3:0]  rsel_q;
  logic [7:0]  code_a_lo_q;
  logic [7:0]  code_a_hi_q;
  logic [7:0]  code_b_lo_q;
  logic [7:0]  code_b_hi_q;
  logic [7:0]  rx_data_q;
  logic [7:0]  rd_q;
  logic        dready_q;
  logic        match_a_q;
  logic        match_b_q;
  logic        eod_q;
  logic [2:0]  slow_s_q;
  logic [1:0]  det_s_q;
  logic [1:0]  ferr_s_q;
  logic [17:0] win_q;
  logic [6:0]  slow_q;
  logic [4:0]  cnt_q;
  logic [16:0] shift_q;
  logic [16:0] rst_q;
  logic        phase_q;
  logic        first_q;

  // reset interval in slow edges, doubled by length select
  function automatic logic [16:0] reset_len(input logic [3:0] sel, input logic lng);
    reset_len = (17'h00001 << sel) << lng;
  endfunction

  // short codes compare low byte only
  function automatic logic code_eq(input logic [15:0] rx, input logic [7:0] hi, input logic [7:0] lo,
                                   input logic sh);
    code_eq = sh ? (rx[7:0] == lo) : (rx == {hi, lo});
  endfunction

  // ==================================================
  // Input synchronisers
  // Pins and the slow clock are asynchronous to CLK_IN
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      slow_s_q <= 3'h0;
      det_s_q  <= 2'h0;
      ferr_s_q <= 2'h0;
    end else if (CE_IN) begin
      slow_s_q <= {slow_s_q[1:0], SLOW_CLK_IN};
      det_s_q  <= {det_s_q[0], DET_DATA_IN};
      ferr_s_q <= {ferr_s_q[0], FREQ_ERR_IN};
    end
  end

  wire slow_edge = slow_s_q[1] && !slow_s_q[2];
  wire carrier   = det_s_q[1];

  // ==================================================
  // Symbol stream from the slicer
  lf_sym_if sym ();

  lf_half_slicer #(
    .HALF_CYC (HALF_BIT_CYC)
  ) u_slicer (
    .clk_in   (CLK_IN),
    .rst_in   (SYS_RST_IN),
    .ce_in    (CE_IN),
    .level_in (carrier),
    .sym      (sym)
  );

  wire rx_on = state_q inside {ACQ_S, PRE_S, SYNC_S, CODE_S, DATA_S};
  assign sym.en = rx_on;

  // ==================================================
  // Manchester pair decoding
  wire pair_done  = sym.valid && phase_q;
  wire pair_bad   = pair_done && (first_q == sym.level);
  // carrier in first half is a zero
  wire bit_val    = !first_q;
  wire zero_ok    = pair_done && first_q && !sym.level;
  wire one_seen   = pair_done && !first_q && sym.level;
  wire sync_pulse = sym.valid && !phase_q && sym.level && sym.long_run;
  wire fault      = sym.err || ferr_s_q[1];

  wire [15:0] code_rx   = {shift_q[14:0], bit_val};
  wire [4:0]  code_last = short_q ? 5'h07 : 5'h0f;
  wire        hit_a     = code_eq(code_rx, code_a_hi_q, code_a_lo_q, short_q);
  wire        hit_b     = code_eq(code_rx, code_b_hi_q, code_b_lo_q, short_q);
  wire        code_done = state_q == CODE_S && pair_done && !pair_bad && cnt_q == code_last;
  wire        byte_done = state_q == DATA_S && pair_done && !pair_bad && cnt_q == 5'h07;
  wire        eod_evt   = state_q == DATA_S && enable_q && (pair_bad || sym.err);
  wire        sync_ok   = {shift_q[15:0], sym.level} == SYNC_PATTERN[16:0];

  // ==================================================
  // Frame state machine
  always_comb begin
    state_d = state_q;
    go_rst  = 1'b0;
    case (state_q)
      // sample period starts on slow edge
      OFF_S: if (slow_edge) state_d = WIN_S;
      WIN_S: begin
        if (carrier) state_d = ACQ_S;
        else if (win_q == 18'h00000) state_d = OFF_S;
      end
      // acquire on five zeros, lost signal resets
      ACQ_S: begin
        if (fault || pair_bad || one_seen || (sym.valid && sym.long_run)) go_rst = 1'b1;
        else if (slow_q >= ACQ_TIMEOUT_EDGES) go_rst = 1'b1;
        else if (zero_ok && cnt_q == ACQ_ZEROS - 5'h01) state_d = PRE_S;
      end
      PRE_S: begin
        if (fault || pair_bad || one_seen || slow_q >= PRE_TIMEOUT_EDGES) go_rst = 1'b1;
        else if (sync_pulse && cnt_q >= PRE_MIN_ZEROS) state_d = SYNC_S;
        else if (sync_pulse) go_rst = 1'b1;
      end
      SYNC_S: begin
        if (fault) go_rst = 1'b1;
        else if (sym.valid && cnt_q == SYNC_HALVES - 5'h02) begin
          if (sync_ok) state_d = CODE_S;
          else go_rst = 1'b1;
        end
      end
      // no match resets, match moves to data
      CODE_S: begin
        if (fault || pair_bad) go_rst = 1'b1;
        else if (code_done && (hit_a || hit_b)) state_d = DATA_S;
        else if (code_done) go_rst = 1'b1;
      end
      // violation or lost carrier ends frame
      DATA_S: if (fault || pair_bad) go_rst = 1'b1;
      RST_S: if (slow_edge && rst_q <= 17'h00001) state_d = OFF_S;
      default: state_d = OFF_S;
    endcase
    if (!enable_q) begin
      state_d = OFF_S;
      go_rst  = 1'b0;
    end
    if (go_rst) state_d = RST_S;
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) state_q <= OFF_S;
    else if (CE_IN) state_q <= state_d;
  end

  // ==================================================
  // Window, time-out and reset-interval counters
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      win_q  <= 18'h00000;
      slow_q <= 7'h00;
    end else if (CE_IN) begin
      if (state_q == OFF_S) win_q <= onsel_q ? 18'(ON_LONG_CYC) : 18'(ON_SHORT_CYC);
      else if (win_q != 18'h00000) win_q <= win_q - 18'h00001;
      // time-out counts slow edges in every state, restarting at each state change
      if (state_d != state_q) slow_q <= 7'h00;
      else if (slow_edge && slow_q != 7'h7f) slow_q <= slow_q + 7'h01;
    end
  end

  // loaded at entry, counted down on slow edges
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) rst_q <= 17'h00000;
    else if (CE_IN && go_rst) rst_q <= reset_len(rsel_q, rlen_q);
    else if (CE_IN && state_q == RST_S && slow_edge) rst_q <= rst_q - 17'h00001;
  end

  // ==================================================
  // Half phase, bit count and shift register
  wire count_en = (state_q inside {ACQ_S, PRE_S} && zero_ok) || (state_q == SYNC_S && sym.valid)
                  || (state_q inside {CODE_S, DATA_S} && pair_done);

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      phase_q <= 1'b0;
      first_q <= 1'b0;
    end else if (CE_IN) begin
      if (state_d != state_q && state_d inside {ACQ_S, CODE_S}) phase_q <= 1'b0;
      else if (sym.valid) phase_q <= !phase_q;
      if (sym.valid && !phase_q) first_q <= sym.level;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cnt_q   <= 5'h00;
      shift_q <= 17'h00000;
    end else if (CE_IN) begin
      if ((state_d != state_q && state_d != PRE_S) || byte_done) cnt_q <= 5'h00;
      else if (count_en && cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
      if (state_d != state_q) shift_q <= 17'h00000;
      else if (state_q == SYNC_S && sym.valid) shift_q <= {shift_q[15:0], sym.level};
      else if (count_en && state_q inside {CODE_S, DATA_S}) shift_q <= {shift_q[15:0], bit_val};
    end
  end

  // ==================================================
  // Register writes
  wire wr_ctrl = WR_IN && ADDR_IN == CTRL_OFF;
  wire ack_wr  = wr_ctrl && WDATA_IN[CTRL_ACK_BIT];
  wire dis_wr  = wr_ctrl && !WDATA_IN[CTRL_EN_BIT];
  wire cfg_wr  = WR_IN && !enable_q;

  // Enable always writable; other control bits only while disabled
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      enable_q <= CTRL_RST[CTRL_EN_BIT];
      irq_en_q <= CTRL_RST[CTRL_IE_BIT];
      short_q  <= CTRL_RST[CTRL_SHORT_BIT];
      rlen_q   <= CTRL_RST[CTRL_RLEN_BIT];
      onsel_q  <= CTRL_RST[CTRL_ONSEL_BIT];
      rsel_q   <= RSEL_RST;
    end else if (CE_IN) begin
      if (wr_ctrl) enable_q <= WDATA_IN[CTRL_EN_BIT];
      if (cfg_wr && ADDR_IN == CTRL_OFF) begin
        irq_en_q <= WDATA_IN[CTRL_IE_BIT];
        short_q  <= WDATA_IN[CTRL_SHORT_BIT];
        rlen_q   <= WDATA_IN[CTRL_RLEN_BIT];
        onsel_q  <= WDATA_IN[CTRL_ONSEL_BIT];
      end
      if (cfg_wr && ADDR_IN == RSEL_OFF) rsel_q <= WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      code_a_lo_q <= CODE_RST;
      code_a_hi_q <= CODE_RST;
      code_b_lo_q <= CODE_RST;
      code_b_hi_q <= CODE_RST;
    end else if (CE_IN && cfg_wr) begin
      if (ADDR_IN == CODE_A_LO_OFF) code_a_lo_q <= WDATA_IN;
      if (ADDR_IN == CODE_A_HI_OFF) code_a_hi_q <= WDATA_IN;
      if (ADDR_IN == CODE_B_LO_OFF) code_b_lo_q <= WDATA_IN;
      if (ADDR_IN == CODE_B_HI_OFF) code_b_hi_q <= WDATA_IN;
    end
  end

  // ==================================================
  // Flags and received data; a set in the clearing cycle wins
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dready_q  <= 1'b0;
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
      eod_q     <= 1'b0;
      rx_data_q <= 8'h00;
    end else if (CE_IN) begin
      match_a_q <= (code_done && hit_a) || (match_a_q && !ack_wr);
      match_b_q <= (code_done && hit_b) || (match_b_q && !ack_wr);
      // every byte overwrites and flags again
      dready_q  <= byte_done || (dready_q && !ack_wr);
      if (byte_done) rx_data_q <= code_rx[7:0];
      // end-of-data, cleared by acknowledge or disable
      eod_q     <= eod_evt || (eod_q && !ack_wr && !dis_wr);
    end
  end

  // ==================================================
  // Outputs
  // only data and end-of-data flags interrupt
  assign IRQ_OUT    = irq_en_q && (dready_q || eod_q);
  // our oscillator request drops; another user holds its own request
  assign DET_EN_OUT = state_q != OFF_S && state_q != RST_S;
  assign OSC_EN_OUT = DET_EN_OUT;

  // reset-active status is the reset state
  wire       rst_active = state_q == RST_S;
  wire [7:0] ctrl_rd    = {3'h0, onsel_q, rlen_q, short_q, irq_en_q, enable_q};
  wire [7:0] status_rd  = {3'h0, rst_active, eod_q, match_b_q, match_a_q, dready_q};
  wire [7:0] rd_mux     = (ADDR_IN == CTRL_OFF)      ? ctrl_rd :
                          (ADDR_IN == RSEL_OFF)      ? {4'h0, rsel_q} :
                          (ADDR_IN == STATUS_OFF)    ? status_rd :
                          (ADDR_IN == RX_DATA_OFF)   ? rx_data_q :
                          (ADDR_IN == CODE_A_LO_OFF) ? code_a_lo_q :
                          (ADDR_IN == CODE_A_HI_OFF) ? code_a_hi_q :
                          (ADDR_IN == CODE_B_LO_OFF) ? code_b_lo_q :
                          (ADDR_IN == CODE_B_HI_OFF) ? code_b_hi_q : 8'h00;

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) rd_q <= 8'h00;
    else if (CE_IN) rd_q <= RD_IN ? rd_mux : 8'h00;
  end
  assign RDATA_OUT = rd_q;

  // ==================================================
  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence s_win_open;
    CE_IN && enable_q && state_q == OFF_S && slow_edge;
  endsequence

  sequence s_ack_only;
    CE_IN && ack_wr && !byte_done && !eod_evt;
  endsequence

  win_start_a: assert property (s_win_open |=> DET_EN_OUT && OSC_EN_OUT && win_q != 18'h00000)
    else $error("window did not open on slow edge");
  idle_off_a: assert property (CE_IN && enable_q && state_q == WIN_S && win_q == 18'h00000 && !carrier
    |=> !DET_EN_OUT)
    else $error("detector left on after empty window");
  lost_sig_a: assert property (CE_IN && enable_q && state_q == ACQ_S && sym.err |=> rst_active && !DET_EN_OUT)
    else $error("lost signal did not power down");
  pre_timeout_a: assert property (CE_IN && enable_q && state_q == PRE_S && slow_q >= PRE_TIMEOUT_EDGES
    |=> rst_active)
    else $error("preamble time-out missed");
  err_noirq_a: assert property (CE_IN && go_rst && state_q != DATA_S |=> !$rose(eod_q) && !$rose(dready_q))
    else $error("reception error raised a flag");
  rst_len_a: assert property (CE_IN && go_rst |=> rst_active && rst_q == reset_len(rsel_q, rlen_q))
    else $error("reset interval not loaded");
  code_lock_a: assert property (CE_IN && enable_q && WR_IN && ADDR_IN == CODE_A_LO_OFF |=> $stable(code_a_lo_q))
    else $error("code register changed while enabled");
  match_flag_a: assert property (CE_IN && code_done && hit_b |=> match_b_q ##1 CE_IN [*2] |-> rst_active || match_b_q || $past(ack_wr))
    else $error("code match flag not set");
  byte_load_a: assert property (CE_IN && byte_done |=> dready_q && rx_data_q == $past(code_rx[7:0]) && (IRQ_OUT == irq_en_q))
    else $error("data byte not delivered");
  ack_clr_a: assert property (s_ack_only |=> !dready_q && !eod_q && !IRQ_OUT)
    else $error("acknowledge did not clear flags");
  eod_set_a: assert property (CE_IN && eod_evt |=> eod_q && rst_active && !DET_EN_OUT)
    else $error("violation did not end frame");
  dis_clr_a: assert property (CE_IN && dis_wr && !eod_evt |=> !eod_q)
    else $error("disable did not clear end-of-data");

endmodule

// >>> dv/lf_tx_model.sv
// Behavioural LF transmitter sending Manchester wake-up frames
`timescale 1ns/1ps
module lf_tx_model
  import lf_wakeup_pkg::*;
#(
  parameter int unsigned HALF = 40
) (
  input  wire logic clk_in,
  output logic      carrier_out
);
  // No carrier is the idle state between frames
  initial carrier_out = 1'b0;
  task automatic hf(input logic c);
    carrier_out <= c;
    repeat (HALF) @(posedge clk_in);
  endtask
  task automatic bt(input logic b);
    hf(!b);
    hf(b);
  endtask
  // Frame: zeros, sync, code, data, then a violation
  task automatic send(input logic [15:0] c, input int nc, input logic [15:0] d, input int nb);
    repeat (10) bt(1'b0);
    for (int i = 17; i >= 0; i--) hf(SYNC_PATTERN[i]);
    for (int i = nc - 1; i >= 0; i--) bt(c[i]);
    for (int i = nb - 1; i >= 0; i--) bt(d[i]);
    // Four carrier halves cannot be valid coding
    repeat (4) hf(1'b1);
    hf(1'b0);
  endtask
endmodule

// >>> dv/lf_wakeup_decoder_tb.sv
// Self-checking bench for the Manchester wake-up decoder
`timescale 1ns/1ps
module lf_wakeup_decoder_tb;
  import lf_wakeup_pkg::*;
  localparam int unsigned HB = 40;
  logic       clk;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       slow = 1'b0;
  logic       car;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] v;
  logic       det;
  logic       osc;
  logic       irq;
  int         failures = 0;
  int         num_checks = 0;
  int         sc = 0;
  // ==========
  // Design, transmitter and clocks
  lf_wakeup_decoder #(.ON_SHORT_CYC(200), .ON_LONG_CYC(400), .HALF_BIT_CYC(HB)) dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .SLOW_CLK_IN(slow), .DET_DATA_IN(car), .FREQ_ERR_IN(1'b0),
    .DET_EN_OUT(det), .OSC_EN_OUT(osc), .IRQ_OUT(irq));
  lf_tx_model #(.HALF(HB)) tx (.clk_in(clk), .carrier_out(car));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Slow timebase of 2000 cycles, long enough for acquisition
  always @(posedge clk) begin
    sc <= (sc == 1999) ? 0 : sc + 1;
    slow <= (sc < 1000);
  end
  // ==========
  // Shared tasks
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic wrb(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  // Bounded wait on irq (s=1) or detector enable (s=0)
  task automatic wt(input bit s, input logic l);
    int n;
    n = 0;
    while (((s ? irq : det) !== l) && n < 8000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8000) begin
      $display("[ERR] wait %0d expected %h seen %h", s, l, !l);
      failures++;
      end_sim();
    end
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    rchk("ctrl", CTRL_OFF, CTRL_RST);
    rchk("code", CODE_A_LO_OFF, CODE_RST);
    wrb(CODE_A_LO_OFF, 8'h34);
    wrb(CODE_A_HI_OFF, 8'h12);
    wrb(CODE_B_LO_OFF, 8'h96);
    wrb(CODE_B_HI_OFF, 8'h55);
    rchk("code_b_hi", CODE_B_HI_OFF, 8'h55);
    wrb(CTRL_OFF, 8'h01);
    wrb(CODE_A_LO_OFF, 8'hff);
    rchk("code_a_lo", CODE_A_LO_OFF, 8'h34);
    rchk("unmapped", 4'hf, 8'h00);
    wrb(CTRL_OFF, 8'h00);
  endtask
  task automatic t_idle();
    wrb(CTRL_OFF, 8'h01);
    wt(0, 1'b1);
    repeat (180) @(posedge clk);
    #1 chk("osc_en", 8'h01, {7'h0, osc});
    repeat (40) @(posedge clk);
    #1 chk("det_en", 8'h00, {7'h0, det});
  endtask
  task automatic t_frame_a();
    wrb(CTRL_OFF, 8'h00);
    wrb(CTRL_OFF, 8'h03);
    fork
      begin
        wt(0, 1'b1);
        tx.send(16'h1234, 16, 16'hc35a, 16);
      end
      begin
        wt(1, 1'b1);
        rchk("status", STATUS_OFF, 8'h03);
        rchk("rx_data", RX_DATA_OFF, 8'hc3);
        wrb(CTRL_OFF, 8'h83);
        wt(1, 1'b0);
        rchk("status", STATUS_OFF, 8'h00);
        wt(1, 1'b1);
        rchk("rx_data", RX_DATA_OFF, 8'h5a);
        wrb(CTRL_OFF, 8'h83);
        wt(1, 1'b0);
        wt(1, 1'b1);
        rchk("status", STATUS_OFF, 8'h18);
        chk("det_en", 8'h00, {7'h0, det});
        wrb(CTRL_OFF, 8'h83);
        rchk("status", STATUS_OFF, 8'h10);
      end
    join
  endtask
  task automatic t_bad();
    fork
      begin
        wt(0, 1'b1);
        tx.send(16'hbeef, 16, 16'h0000, 0);
      end
      begin
        wt(0, 1'b1);
        wt(0, 1'b0);
        rchk("status", STATUS_OFF, 8'h10);
        chk("irq", 8'h00, {7'h0, irq});
      end
    join
    repeat (2500) @(posedge clk);
    rchk("status", STATUS_OFF, 8'h00);
  endtask
  task automatic t_short();
    wrb(CTRL_OFF, 8'h00);
    wrb(CTRL_OFF, 8'h07);
    fork
      begin
        wt(0, 1'b1);
        tx.send(16'h0096, 8, 16'h00a4, 8);
      end
      begin
        wt(1, 1'b1);
        rchk("status", STATUS_OFF, 8'h05);
        rchk("rx_data", RX_DATA_OFF, 8'ha4);
        wrb(CTRL_OFF, 8'h87);
        wt(1, 1'b0);
        wt(1, 1'b1);
        wrb(CTRL_OFF, 8'h06);
        wt(1, 1'b0);
        rchk("status", STATUS_OFF, 8'h00);
      end
    join
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_idle();
    t_frame_a();
    t_bad();
    t_short();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule
